// [hw/ercb_top.v]
// Embedded memory block: single-port RAM/ROM with aspect ratios, or a 32x32 CAM.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ercb_consts.vh"

module ercb_top #(
  parameter [15:0] RAM_INIT_SEED = 16'h0000,
  parameter CAM_PRELOAD = 0,
  parameter [31:0] CAM_INIT_BASE = 32'h00000000
) (
  input wire CLK_IN,
  input wire NRST_IN,
  input wire CLK_EN_IN,
  input wire LOCAL_CLR_IN,
  input wire GLOBAL_CLR_IN,
  input wire [31:0] DATA_IN,
  input wire [10:0] ADDR_IN,
  input wire WREN_IN,
  input wire READ_STROBE_IN,
  input wire DONT_CARE_IN,
  input wire IN_CLKEN_IN,
  input wire OUT_CLKEN_IN,
  output reg [15:0] Q_OUT,
  output reg MATCH_OUT,
  input wire [3:0] AXI_AWADDR_IN,
  input wire AXI_AWVALID_IN,
  output reg AXI_AWREADY_OUT,
  input wire [31:0] AXI_WDATA_IN,
  input wire [3:0] AXI_WSTRB_IN,
  input wire AXI_WVALID_IN,
  output reg AXI_WREADY_OUT,
  output reg [1:0] AXI_BRESP_OUT,
  output reg AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  input wire [3:0] AXI_ARADDR_IN,
  input wire AXI_ARVALID_IN,
  output reg AXI_ARREADY_OUT,
  output reg [31:0] AXI_RDATA_OUT,
  output reg [1:0] AXI_RRESP_OUT,
  output reg AXI_RVALID_OUT,
  input wire AXI_RREADY_IN
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  // Word index inside the 128x16 store for the chosen aspect.
  function [6:0] word_idx(input [10:0] a, input [2:0] k);
    reg [10:0] t;
    begin
      t = a >> k;
      word_idx = t[6:0];
    end
  endfunction

  // Bit offset of the narrow lane inside the stored word.
  function [3:0] lane_shift(input [10:0] a, input [2:0] k);
    reg [10:0] lsb;
    reg [10:0] w;
    reg [10:0] s;
    begin
      lsb = a & ((11'h001 << k) - 11'h001);
      w = 11'h010 >> k;
      s = lsb * w;
      lane_shift = s[3:0];
    end
  endfunction

  function [15:0] lane_mask(input [10:0] a, input [2:0] k);
    reg [31:0] m;
    begin
      m = ((32'h00000001 << (32'h00000010 >> k)) - 32'h00000001) << lane_shift(a, k);
      lane_mask = m[15:0];
    end
  endfunction

  // Lowest matching entry; duplicates give only the first.
  function [4:0] first_hit(input [31:0] h);
    integer i;
    begin
      first_hit = 5'h00;
      for (i = `ERCB_CAM_WORDS - 1; i >= 0; i = i - 1)
        if (h[i])
          first_hit = i[4:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration and effective input paths
  // ---------------------------------------------------------------------------
  wire arst_n = NRST_IN & ~LOCAL_CLR_IN & ~GLOBAL_CLR_IN;
  reg [`ERCB_CTRL_W-1:0] ctrl_q;
  reg [31:0] din_q;
  reg [10:0] addr_q;
  reg we_q;
  reg re_q;
  reg [1:0] st_q;
  reg [4:0] cw_addr_q;
  reg [31:0] cw_data_q;
  reg cw_mask_q;
  reg [15:0] ram_q [0:`ERCB_RAM_WORDS-1];
  reg [31:0] cam_q [0:`ERCB_CAM_WORDS-1];
  reg [31:0] dc_q [0:`ERCB_CAM_WORDS-1];
  reg [31:0] vld_q;
  reg [15:0] rd_q;
  reg [15:0] lp_q;
  reg [31:0] hit_q;
  reg [4:0] idx_q;
  reg phase_q;
  wire cam_mode = ctrl_q[`ERCB_C_CAM];
  wire rom_mode = ctrl_q[`ERCB_C_ROM];
  wire [2:0] asp = ctrl_q[`ERCB_C_ASP_HI:`ERCB_C_ASP_LO];
  wire active = CLK_EN_IN & IN_CLKEN_IN;
  // Data, address and the write and read strobes are taken either from their input registers or straight from the port.
  wire [31:0] din_e = ctrl_q[`ERCB_C_REG_DIN] ? din_q : DATA_IN;
  wire [10:0] raddr_e = ctrl_q[`ERCB_C_REG_RADDR] ? addr_q : ADDR_IN;
  wire [10:0] waddr_e = ctrl_q[`ERCB_C_REG_WADDR] ? addr_q : ADDR_IN;
  wire we_e = ctrl_q[`ERCB_C_REG_WE] ? we_q : WREN_IN;
  wire re_e = ctrl_q[`ERCB_C_REG_RE] ? re_q : READ_STROBE_IN;
  // Writes win over reads on the single shared port.
  wire ram_wr = active & we_e & ~cam_mode & ~rom_mode;
  wire ram_rd = active & re_e & ~we_e & ~cam_mode;
  wire cam_wr = active & we_e & cam_mode & ~rom_mode & (st_q == `ERCB_ST_IDLE);
  wire search = active & re_e & ~we_e & cam_mode & (st_q == `ERCB_ST_IDLE);
  wire [15:0] rword = ram_q[word_idx(raddr_e, asp)];
  wire [15:0] rlane = (rword & lane_mask(raddr_e, asp)) >> lane_shift(raddr_e, asp);
  wire [15:0] wword = ram_q[word_idx(waddr_e, asp)];
  wire [15:0] wlane = (din_e[15:0] << lane_shift(waddr_e, asp)) & lane_mask(waddr_e, asp);
  wire [31:0] hit;

  genvar g;
  generate
    for (g = 0; g < `ERCB_CAM_WORDS; g = g + 1)
    begin : cmp
      // Every entry compares in parallel; don't-care bits are masked out.
      assign hit[g] = vld_q[g] & (((cam_q[g] ^ din_e) & ~dc_q[g]) == 32'h00000000);
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Input registers and CAM write sequence
  // ---------------------------------------------------------------------------
  always @(posedge CLK_IN or negedge arst_n)
  begin
    if (!arst_n)
    begin
      din_q <= 32'h00000000;
      addr_q <= 11'h000;
      we_q <= 1'b0;
      re_q <= 1'b0;
      st_q <= `ERCB_ST_IDLE;
      cw_addr_q <= 5'h00;
      cw_data_q <= 32'h00000000;
      cw_mask_q <= 1'b0;
    end
    else if (active)
    begin
      din_q <= DATA_IN;
      addr_q <= ADDR_IN;
      we_q <= WREN_IN;
      re_q <= READ_STROBE_IN;
      case (st_q)
        `ERCB_ST_IDLE:
        begin
          if (cam_wr)
          begin
            cw_addr_q <= waddr_e[4:0];
            cw_data_q <= din_e;
            cw_mask_q <= DONT_CARE_IN;
            st_q <= `ERCB_ST_DATA;
          end
        end
        `ERCB_ST_DATA:
          st_q <= cw_mask_q ? `ERCB_ST_MASK : `ERCB_ST_IDLE;
        `ERCB_ST_MASK:
          st_q <= `ERCB_ST_IDLE;
        default:
          st_q <= `ERCB_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Storage; loaded with configuration contents by the chip-wide reset
  // ---------------------------------------------------------------------------
  integer i;
  always @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      for (i = 0; i < `ERCB_RAM_WORDS; i = i + 1)
        ram_q[i] <= RAM_INIT_SEED ^ i[15:0];
      for (i = 0; i < `ERCB_CAM_WORDS; i = i + 1)
      begin
        cam_q[i] <= CAM_INIT_BASE + i[31:0];
        dc_q[i] <= 32'h00000000;
      end
      vld_q <= (CAM_PRELOAD != 0) ? 32'hFFFFFFFF : 32'h00000000;
    end
    else if (active)
    begin
      if (ram_wr)
        ram_q[word_idx(waddr_e, asp)] <= (wword & ~lane_mask(waddr_e, asp)) | wlane;
      if (st_q == `ERCB_ST_DATA)
      begin
        cam_q[cw_addr_q] <= cw_data_q;
        dc_q[cw_addr_q] <= 32'h00000000;
        vld_q[cw_addr_q] <= 1'b1;
      end
      if (st_q == `ERCB_ST_MASK)
        dc_q[cw_addr_q] <= din_e;
    end
  end

  // ---------------------------------------------------------------------------
  // Read and search pipeline, data output register
  // ---------------------------------------------------------------------------
  wire [15:0] ram_sel = ctrl_q[`ERCB_C_LOWPWR] ? lp_q : rd_q;
  reg [15:0] q_next;
  always @*
  begin
    q_next = Q_OUT;
    if (cam_mode)
    begin
      if (search)
        q_next = ctrl_q[`ERCB_C_UNENC] ? hit[15:0] : {11'h000, first_hit(hit)};
      else if (phase_q)
        q_next = hit_q[31:16];
    end
    else if (!ctrl_q[`ERCB_C_REG_DOUT] || OUT_CLKEN_IN)
      q_next = ram_sel;
  end

  always @(posedge CLK_IN or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_q <= 16'h0000;
      lp_q <= 16'h0000;
      hit_q <= 32'h00000000;
      idx_q <= 5'h00;
      phase_q <= 1'b0;
      Q_OUT <= 16'h0000;
      MATCH_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (ram_rd)
        rd_q <= rlane;
      lp_q <= rd_q;
      Q_OUT <= q_next;
      phase_q <= search & ctrl_q[`ERCB_C_UNENC];
      if (search)
      begin
        hit_q <= hit;
        idx_q <= first_hit(hit);
        MATCH_OUT <= |hit;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite register slave
  // ---------------------------------------------------------------------------
  reg aw_hold_q;
  reg w_hold_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [31:0] wr_merge;
  integer b;
  always @*
  begin
    wr_merge = {{(32 - `ERCB_CTRL_W){1'b0}}, ctrl_q};
    for (b = 0; b < 4; b = b + 1)
      if (w_strb_q[b])
        wr_merge[b * 8 +: 8] = w_data_q[b * 8 +: 8];
    if (wr_merge[`ERCB_C_ASP_HI:`ERCB_C_ASP_LO] > `ERCB_ASP_MAX)
      wr_merge[`ERCB_C_ASP_HI:`ERCB_C_ASP_LO] = `ERCB_ASP_MAX;
  end

  wire [31:0] stat_word = {23'h000000, idx_q, 2'h0, (st_q != `ERCB_ST_IDLE), MATCH_OUT};

  always @(posedge CLK_IN or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `ERCB_CTRL_RST;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      AXI_AWREADY_OUT <= 1'b1;
      AXI_WREADY_OUT <= 1'b1;
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `ERCB_AXI_OKAY;
      AXI_ARREADY_OUT <= 1'b1;
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h00000000;
      AXI_RRESP_OUT <= `ERCB_AXI_OKAY;
    end
    else if (CLK_EN_IN)
    begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= AXI_AWADDR_IN;
        AXI_AWREADY_OUT <= 1'b0;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= AXI_WDATA_IN;
        w_strb_q <= AXI_WSTRB_IN;
        AXI_WREADY_OUT <= 1'b0;
      end
      if (aw_hold_q && w_hold_q && !AXI_BVALID_OUT)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        AXI_BVALID_OUT <= 1'b1;
        if (aw_addr_q == `ERCB_CTRL_ADDR)
        begin
          ctrl_q <= wr_merge[`ERCB_CTRL_W-1:0];
          AXI_BRESP_OUT <= `ERCB_AXI_OKAY;
        end
        else if (aw_addr_q == `ERCB_STAT_ADDR)
          AXI_BRESP_OUT <= `ERCB_AXI_OKAY;
        else
          AXI_BRESP_OUT <= `ERCB_AXI_SLVERR;
      end
      if (AXI_BVALID_OUT && AXI_BREADY_IN)
      begin
        AXI_BVALID_OUT <= 1'b0;
        AXI_AWREADY_OUT <= 1'b1;
        AXI_WREADY_OUT <= 1'b1;
      end
      if (AXI_ARVALID_IN && AXI_ARREADY_OUT)
      begin
        AXI_ARREADY_OUT <= 1'b0;
        AXI_RVALID_OUT <= 1'b1;
        if (AXI_ARADDR_IN == `ERCB_CTRL_ADDR)
        begin
          AXI_RDATA_OUT <= {{(32 - `ERCB_CTRL_W){1'b0}}, ctrl_q};
          AXI_RRESP_OUT <= `ERCB_AXI_OKAY;
        end
        else if (AXI_ARADDR_IN == `ERCB_STAT_ADDR)
        begin
          AXI_RDATA_OUT <= stat_word;
          AXI_RRESP_OUT <= `ERCB_AXI_OKAY;
        end
        else
        begin
          AXI_RDATA_OUT <= 32'h00000000;
          AXI_RRESP_OUT <= `ERCB_AXI_SLVERR;
        end
      end
      if (AXI_RVALID_OUT && AXI_RREADY_IN)
      begin
        AXI_RVALID_OUT <= 1'b0;
        AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

endmodule // ercb_top

// [inc/ercb_consts.vh]
// Constants for the embedded RAM and CAM memory block.
`ifndef ERCB_CONSTS_VH
`define ERCB_CONSTS_VH

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define ERCB_CTRL_ADDR 4'h0
`define ERCB_STAT_ADDR 4'h4
`define ERCB_AXI_OKAY 2'h0
`define ERCB_AXI_SLVERR 2'h2

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define ERCB_CTRL_W 13
`define ERCB_CTRL_RST 13'h1F80
`define ERCB_C_CAM 0
`define ERCB_C_UNENC 1
`define ERCB_C_ASP_LO 2
`define ERCB_C_ASP_HI 4
`define ERCB_C_ROM 5
`define ERCB_C_LOWPWR 6
`define ERCB_C_REG_DIN 7
`define ERCB_C_REG_DOUT 8
`define ERCB_C_REG_RADDR 9
`define ERCB_C_REG_WADDR 10
`define ERCB_C_REG_WE 11
`define ERCB_C_REG_RE 12
`define ERCB_ASP_MAX 3'h4

// ---------------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------------
`define ERCB_S_MATCH 0
`define ERCB_S_BUSY 1
`define ERCB_S_IDX_LO 4
`define ERCB_S_IDX_HI 8

// ---------------------------------------------------------------------------
// Geometry and CAM write sequence states
// ---------------------------------------------------------------------------
`define ERCB_RAM_W 16
`define ERCB_RAM_WORDS 128
`define ERCB_CAM_WORDS 32
`define ERCB_CAM_W 32
`define ERCB_ST_IDLE 2'h0
`define ERCB_ST_DATA 2'h1
`define ERCB_ST_MASK 2'h2

`endif

// [verif/ercb_checker_sva.sv]
// Concurrent checks on the ports of the embedded RAM and CAM block.
`timescale 1ns/1ps
module ercb_checker (
  input wire CLK_IN,
  input wire NRST_IN,
  input wire LOCAL_CLR_IN,
  input wire GLOBAL_CLR_IN,
  input wire READ_STROBE_IN,
  input wire [15:0] Q_OUT,
  input wire MATCH_OUT,
  input wire AXI_AWVALID_IN,
  input wire AXI_AWREADY_OUT,
  input wire AXI_WVALID_IN,
  input wire AXI_WREADY_OUT,
  input wire [1:0] AXI_BRESP_OUT,
  input wire AXI_BVALID_OUT,
  input wire AXI_BREADY_IN,
  input wire [3:0] AXI_ARADDR_IN,
  input wire AXI_ARVALID_IN,
  input wire AXI_ARREADY_OUT,
  input wire [31:0] AXI_RDATA_OUT,
  input wire [1:0] AXI_RRESP_OUT,
  input wire AXI_RVALID_OUT,
  input wire AXI_RREADY_IN
);
  wire rst_ok;
  reg [2:0] since_rd_q;
  assign rst_ok = NRST_IN & ~LOCAL_CLR_IN & ~GLOBAL_CLR_IN;
  default clocking dcb @(posedge CLK_IN); endclocking
  default disable iff (!rst_ok);

  // ---------------------------------------------------------------------------
  // Cycles since the last read or search strobe, saturating at seven.
  // ---------------------------------------------------------------------------
  always @(posedge CLK_IN or negedge NRST_IN)
    if (!NRST_IN)
      since_rd_q <= 3'h7;
    else if (READ_STROBE_IN)
      since_rd_q <= 3'h0;
    else if (since_rd_q != 3'h7)
      since_rd_q <= since_rd_q + 3'h1;

  a_reset_zero: assert property (disable iff (1'b0) !rst_ok |-> Q_OUT == 16'h0000
    && !MATCH_OUT && !AXI_BVALID_OUT && !AXI_RVALID_OUT && AXI_ARREADY_OUT)
    else $error("outputs not cleared during reset");
  a_match_cause: assert property ($changed(MATCH_OUT) |-> since_rd_q <= 3'h2)
    else $error("match flag moved without a search");
  a_q_cause: assert property ($changed(Q_OUT) |-> since_rd_q <= 3'h5)
    else $error("data output moved without a read");
  a_ar_answer: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT
    |=> AXI_RVALID_OUT && !AXI_ARREADY_OUT)
    else $error("read answer late");
  a_r_hold: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN
    |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
    else $error("read answer dropped early");
  a_b_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN
    |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
    else $error("write answer dropped early");
  a_b_refuse: assert property (AXI_BVALID_OUT |-> !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
    else $error("new write taken while answer pending");
  a_b_timely: assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN
    && AXI_WREADY_OUT |-> ##[1:2] AXI_BVALID_OUT)
    else $error("write answer late");
  a_bad_addr: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT && AXI_ARADDR_IN != 4'h0
    && AXI_ARADDR_IN != 4'h4 |=> AXI_RRESP_OUT == 2'h2 && AXI_RDATA_OUT == 32'h00000000)
    else $error("unmapped read not refused");
endmodule // ercb_checker

bind ercb_top ercb_checker ercb_checker_i (.CLK_IN, .NRST_IN, .LOCAL_CLR_IN, .GLOBAL_CLR_IN,
  .READ_STROBE_IN, .Q_OUT, .MATCH_OUT, .AXI_AWVALID_IN, .AXI_AWREADY_OUT, .AXI_WVALID_IN,
  .AXI_WREADY_OUT, .AXI_BRESP_OUT, .AXI_BVALID_OUT, .AXI_BREADY_IN, .AXI_ARADDR_IN,
  .AXI_ARVALID_IN, .AXI_ARREADY_OUT, .AXI_RDATA_OUT, .AXI_RRESP_OUT, .AXI_RVALID_OUT,
  .AXI_RREADY_IN);

// [verif/ercb_user_model.sv]
// Behavioural user logic that drives the memory port of the block.
`timescale 1ns/1ps
module ercb_user_model (
  input wire clk_in,
  output logic [31:0] data_out,
  output logic [10:0] addr_out,
  output logic wren_out,
  output logic rd_out,
  output logic dc_out
);
  initial
  begin
    data_out = 32'h00000000;
    addr_out = 11'h000;
    wren_out = 1'b0;
    rd_out = 1'b0;
    dc_out = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Transfers; write and read strobes are never high together.
  // ---------------------------------------------------------------------------
  task automatic ram_write(input logic [10:0] a, input logic [31:0] d);
    addr_out <= a;
    data_out <= d;
    wren_out <= 1'b1;
    @(posedge clk_in);
    wren_out <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic ram_read(input logic [10:0] a);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    repeat (5) @(posedge clk_in);
  endtask

  // The mask word follows the entry word two cycles later; duplicate entries are not prevented.
  task automatic cam_write(input logic [4:0] a, input logic [31:0] w, input logic [31:0] m,
    input logic use_mask);
    addr_out <= {6'h00, a};
    data_out <= w;
    wren_out <= 1'b1;
    dc_out <= use_mask;
    @(posedge clk_in);
    wren_out <= 1'b0;
    dc_out <= 1'b0;
    @(posedge clk_in);
    data_out <= m;
    @(posedge clk_in);
    data_out <= ~m;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic cam_search(input logic [31:0] w);
    data_out <= w;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    data_out <= ~w;
  endtask
endmodule // ercb_user_model

// [verif/test_embedded_ram_cam_block.sv]
// Self-checking bench for the embedded RAM and CAM block.
`timescale 1ns/1ps
`include "ercb_consts.vh"
module test_embedded_ram_cam_block;
  localparam logic [15:0] SEED = 16'hA5C3;
  logic clk = 1'b0;
  logic nrst = 1'b1;
  logic clk_en = 1'b1;
  logic lclr = 1'b0;
  logic gclr = 1'b0;
  logic in_ce = 1'b1;
  logic out_ce = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [3:0] araddr = 4'h0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire [31:0] data;
  wire [10:0] addr;
  wire wren, rd, dc, match, awready, wready, bvalid, arready, rvalid;
  wire [15:0] q;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int error_cnt = 0;
  int comparisons = 0;
  logic [15:0] pat, mask;

  always #5 clk = ~clk;

  ercb_user_model ercb_user_model_i (.clk_in(clk), .data_out(data), .addr_out(addr),
    .wren_out(wren), .rd_out(rd), .dc_out(dc));
  ercb_top #(.RAM_INIT_SEED(SEED), .CAM_PRELOAD(1), .CAM_INIT_BASE(32'h10000000)) ercb_top_i (
    .CLK_IN(clk), .NRST_IN(nrst), .CLK_EN_IN(clk_en), .LOCAL_CLR_IN(lclr),
    .GLOBAL_CLR_IN(gclr), .DATA_IN(data), .ADDR_IN(addr), .WREN_IN(wren),
    .READ_STROBE_IN(rd), .DONT_CARE_IN(dc), .IN_CLKEN_IN(in_ce), .OUT_CLKEN_IN(out_ce),
    .Q_OUT(q), .MATCH_OUT(match), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

  // ---------------------------------------------------------------------------
  // Comparison, closing report and bus tasks.
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    // A free edge keeps the release of the last answer apart from the next request.
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 60);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    if (!bvalid)
    begin
      error_cnt++;
      end_sim;
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 60);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    if (!rvalid)
    begin
      error_cnt++;
      end_sim;
    end
  endtask

  task automatic ctrl(input logic [31:0] v);
    axi_wr(`ERCB_CTRL_ADDR, v, `ERCB_AXI_OKAY);
  endtask

  task automatic rd_chk(input logic [10:0] a, input logic [15:0] e, input logic [15:0] m);
    ercb_user_model_i.ram_read(a);
    chk({16'h0, q & m}, {16'h0, e & m});
  endtask

  task automatic find(input logic [31:0] w, input logic m, input logic [15:0] lo,
    input logic [15:0] hi, input logic two);
    ercb_user_model_i.cam_search(w);
    #1;
    chk({31'h0, match}, {31'h0, m});
    if (m)
      chk({16'h0, q}, {16'h0, lo});
    if (two)
    begin
      @(posedge clk);
      #1;
      chk({16'h0, q}, {16'h0, hi});
    end
    @(posedge clk);
  endtask

  initial
  begin
    // Reset is asserted at time zero so every register takes its reset value before the first edge.
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({15'h0, q, match}, 32'h00000000);
    axi_rd(`ERCB_CTRL_ADDR, 32'h00001F80, `ERCB_AXI_OKAY);
    axi_rd(`ERCB_STAT_ADDR, 32'h00000000, `ERCB_AXI_OKAY);
    axi_rd(4'h8, 32'h00000000, `ERCB_AXI_SLVERR);
    axi_wr(4'hC, 32'h00000001, `ERCB_AXI_SLVERR);
    axi_wr(`ERCB_STAT_ADDR, 32'hFFFFFFFF, `ERCB_AXI_OKAY);
    axi_rd(`ERCB_STAT_ADDR, 32'h00000000, `ERCB_AXI_OKAY);
    rd_chk(11'd100, SEED ^ 16'd100, 16'hFFFF);
    ctrl(32'h00000020);
    ercb_user_model_i.ram_write(11'd100, 32'h00005555);
    rd_chk(11'd100, SEED ^ 16'd100, 16'hFFFF);
    pat = 16'h3C5A;
    for (int k = 0; k < 5; k++)
    begin
      ctrl(k << 2);
      mask = 16'hFFFF >> (16 - (16 >> k));
      ercb_user_model_i.ram_write(11'd8, {16'h0, ~pat});
      ercb_user_model_i.ram_write(11'd9, {16'h0, pat});
      rd_chk(11'd8, ~pat, mask);
      rd_chk(11'd9, pat, mask);
    end
    ctrl(32'h00000040);
    rd_chk(11'd9, pat, 16'hFFFF);
    for (int i = 0; i < 2; i++)
    begin
      ctrl(32'h00000000);
      in_ce <= (i != 0);
      clk_en <= (i == 0);
      ercb_user_model_i.ram_write(11'd7, 32'h0000BEEF);
      in_ce <= 1'b1;
      clk_en <= 1'b1;
      rd_chk(11'd7, SEED ^ 16'd7, 16'hFFFF);
    end
    ctrl(32'h00000100);
    out_ce <= 1'b0;
    rd_chk(11'h005, SEED ^ 16'h0007, 16'hFFFF);
    out_ce <= 1'b1;
    rd_chk(11'h005, SEED ^ 16'h0005, 16'hFFFF);
    ctrl(32'h0000001C);
    axi_rd(`ERCB_CTRL_ADDR, 32'h00000010, `ERCB_AXI_OKAY);
    ctrl(32'h00000001);
    find(32'h10000007, 1'b1, 16'd7, 16'h0, 1'b0);
    ercb_user_model_i.cam_write(5'd12, 32'hFA12FA12, 32'h0, 1'b0);
    find(32'hFA12FA12, 1'b1, 16'd12, 16'h0, 1'b0);
    axi_rd(`ERCB_STAT_ADDR, 32'h000000C1, `ERCB_AXI_OKAY);
    find(32'h0BADF00D, 1'b0, 16'h0, 16'h0, 1'b0);
    ercb_user_model_i.cam_write(5'd20, 32'h0000ABCD, 32'h000000FF, 1'b1);
    find(32'h0000AB00, 1'b1, 16'd20, 16'h0, 1'b0);
    ctrl(32'h00000003);
    ercb_user_model_i.cam_write(5'd3, 32'h77770001, 32'h0, 1'b0);
    ercb_user_model_i.cam_write(5'd18, 32'h77770001, 32'h0, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      ctrl(32'h00000003);
      find(32'h77770001, 1'b1, 16'h0008, 16'h0004, 1'b1);
      lclr <= (i == 0);
      gclr <= (i != 0);
      @(posedge clk);
      lclr <= 1'b0;
      gclr <= 1'b0;
      @(posedge clk);
      chk({15'h0, q, match}, 32'h00000000);
      axi_rd(`ERCB_CTRL_ADDR, 32'h00001F80, `ERCB_AXI_OKAY);
    end
    end_sim;
  end
endmodule // test_embedded_ram_cam_block
